// *** core/cpc_pkg.sv ***
// Constants, field layouts and carrier types for the comparator pair control block
// Operation
// - Edge mode picks any, falling or rising trigger
// - Level field enables request and sets priority
// - Hysteresis code none, small, large passed out
// - Comparator works only while enable is one
// - Plus select picks pins 0-6 or converter
// - Minus select picks pins, converter, bandgap, scaler
// - Invert bit flips output for pin and events
// - Pin drive bit puts output onto pin
// - Scaler equals supply times factor plus one, /64
// - Window operation only while window enable set
// - Window mode: above, inside, below, outside trigger
// - Window level enables window request, sets priority
// - Raw output high when plus exceeds minus
// - Events fire whether or not interrupt enabled
// - Flags set on condition, clear by ack/one
// - Window position coded above, inside, below, outside
package cpc_pkg;

  // ****************************************************************
  // Register word indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [5:0] IDX_CMP0_CTRL = 6'h00;
  localparam logic [5:0] IDX_CMP1_CTRL = 6'h01;
  localparam logic [5:0] IDX_CMP0_MUX = 6'h02;
  localparam logic [5:0] IDX_CMP1_MUX = 6'h03;
  localparam logic [5:0] IDX_INV_ROUTE = 6'h04;
  localparam logic [5:0] IDX_SCALE = 6'h05;
  localparam logic [5:0] IDX_WINDOW = 6'h06;
  localparam logic [5:0] IDX_STATUS = 6'h07;
  localparam logic [5:0] IDX_IRQ_STATUS = 6'h0a;
  localparam logic [5:0] IDX_IRQ_MASK = 6'h0b;

  // ****************************************************************
  // Writable bit masks and reset values
  // ****************************************************************
  localparam logic [7:0] MASK_CTRL = 8'hf7;
  localparam logic [7:0] MASK_MUX = 8'h3f;
  localparam logic [7:0] MASK_INV_ROUTE = 8'h0f;
  localparam logic [7:0] MASK_SCALE = 8'h3f;
  localparam logic [7:0] MASK_WINDOW = 8'h1f;
  localparam logic [2:0] MASK_FLAGS = 3'h7;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  // ****************************************************************
  // Field positions and codes
  // ****************************************************************
  localparam int INV_BIT_BASE = 2;
  localparam int DRIVE_BIT_BASE = 0;
  localparam int FLAG_WINDOW = 2;
  localparam int SCALE_DIVISOR = 64;
  localparam logic [1:0] EDGE_ANY = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_RISE = 2'h3;
  localparam logic [1:0] HYST_RESERVED = 2'h3;
  localparam logic [1:0] HYST_NONE = 2'h0;
  localparam logic [1:0] WIN_ABOVE = 2'h0;
  localparam logic [1:0] WIN_INSIDE = 2'h1;
  localparam logic [1:0] WIN_BELOW = 2'h2;
  localparam logic [1:0] WIN_OUTSIDE = 2'h3;
  localparam logic [1:0] LEVEL_OFF = 2'h0;

  // ****************************************************************
  // Carrier types
  // ****************************************************************
  typedef struct packed {
    logic [1:0] edge_trigger_select;
    logic [1:0] compare_irq_level;
    logic reserved;
    logic [1:0] hysteresis_select;
    logic enable;
  } cpc_cmp_ctrl_type;

  typedef struct packed {
    logic [1:0] reserved;
    logic [2:0] plus_input_select;
    logic [2:0] minus_input_select;
  } cpc_mux_type;

  typedef struct packed {
    logic [2:0] reserved;
    logic window_enable;
    logic [1:0] window_trigger_select;
    logic [1:0] window_irq_level;
  } cpc_win_type;

  typedef struct packed {
    logic enable;
    logic [1:0] hysteresis_select;
    logic [2:0] plus_input_select;
    logic [2:0] minus_input_select;
  } cpc_afe_cfg_type;

endpackage : cpc_pkg

// *** core/cpc_comparator_pair.sv ***
// Comparator pair control: AXI4-Lite registers, edge and window events, flags
`timescale 1ns/10ps
module cpc_comparator_pair (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Analog front end
  input wire logic [1:0] comp_raw_i,
  output cpc_pkg::cpc_afe_cfg_type [1:0] afe_cfg_o,
  output logic [6:0] supply_scale_num_o,
  // Port pins
  output logic [1:0] cmp_pin_o,
  output logic [1:0] cmp_pin_oe_n_o,
  // Events
  output logic [1:0] cmp_event_o,
  output logic window_event_o,
  // Interrupt vectors and summary interrupt
  input wire logic [2:0] vec_ack_i,
  output logic [2:0] irq_req_o,
  output logic [2:0][1:0] irq_level_o,
  output logic irq_o
);
  import cpc_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  cpc_cmp_ctrl_type ctrl_reg [2];
  cpc_mux_type mux_reg [2];
  logic [7:0] inv_route_reg;
  logic [5:0] scale_reg;
  cpc_win_type win_reg;
  logic [2:0] flag_reg;
  logic [2:0] irq_stat_reg;
  logic [2:0] irq_mask_reg;
  logic [1:0] sync1_reg;
  logic [1:0] sync2_reg;
  logic [1:0] out_prev_reg;
  logic [1:0] en_d_reg;
  logic [1:0] cmp_out;
  logic [1:0] cmp_trig;
  logic [1:0] cmp_pin_reg;
  logic [1:0] cmp_event_reg;
  logic win_on;
  logic win_on_d_reg;
  logic win_match;
  logic win_match_prev_reg;
  logic win_trig;
  logic window_event_reg;
  logic [1:0] win_pos;
  logic [2:0] trig_all;
  logic aw_full_reg;
  logic w_full_reg;
  logic [5:0] aw_idx_reg;
  logic [7:0] w_byte_reg;
  logic w_lane0_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [7:0] rdata_reg;
  logic do_write;
  logic wr_hit;
  logic wr_en;
  logic rd_take;
  logic [5:0] rd_idx;
  logic rd_hit;
  logic [7:0] rd_byte;
  logic [7:0] status_byte;
  logic [2:0] w1c_clear;
  logic irq_stat_rd_clear;

  // ****************************************************************
  // Input synchroniser
  // ****************************************************************
  // The front end already drives one when plus exceeds minus
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_reg <= 2'h0;
      sync2_reg <= 2'h0;
    end else begin
      sync1_reg <= comp_raw_i;
      sync2_reg <= sync1_reg;
    end
  end

  // ****************************************************************
  // Per-comparator output, edge detection and pin drive
  // ****************************************************************
  for (genvar k = 0; k < 2; k++) begin : g_cmp
    logic rise;
    logic fall;
    // Disabled comparator reads as low so it can never make edges
    assign cmp_out[k] = ctrl_reg[k].enable & (sync2_reg[k] ^ inv_route_reg[INV_BIT_BASE + k]);
    assign rise = cmp_out[k] & ~out_prev_reg[k];
    assign fall = ~cmp_out[k] & out_prev_reg[k];
    // First cycle after enable is skipped so the enable itself is no edge
    always_comb begin
      cmp_trig[k] = 1'b0;
      if (ctrl_reg[k].enable && en_d_reg[k]) begin
        case (ctrl_reg[k].edge_trigger_select)
          EDGE_ANY: cmp_trig[k] = rise | fall;
          EDGE_FALL: cmp_trig[k] = fall;
          EDGE_RISE: cmp_trig[k] = rise;
          default: cmp_trig[k] = 1'b0;
        endcase
      end
    end
    assign afe_cfg_o[k].enable = ctrl_reg[k].enable;
    assign afe_cfg_o[k].hysteresis_select = (ctrl_reg[k].hysteresis_select == HYST_RESERVED) ?
        HYST_NONE : ctrl_reg[k].hysteresis_select;
    assign afe_cfg_o[k].plus_input_select = mux_reg[k].plus_input_select;
    assign afe_cfg_o[k].minus_input_select = mux_reg[k].minus_input_select;
    assign cmp_pin_oe_n_o[k] = ~(inv_route_reg[DRIVE_BIT_BASE + k] & ctrl_reg[k].enable);
    assign irq_level_o[k] = ctrl_reg[k].compare_irq_level;

    a_rise_mode_event: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (ctrl_reg[k].enable && en_d_reg[k] && ctrl_reg[k].edge_trigger_select == EDGE_RISE
       && cmp_out[k] && !out_prev_reg[k]) |=> cmp_event_o[k])
      else $error("rising edge in rise mode gave no event");
    a_fall_mode_quiet: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (ctrl_reg[k].edge_trigger_select == EDGE_FALL && $rose(cmp_out[k])) |=> !cmp_event_o[k])
      else $error("rising edge in fall mode gave an event");
    a_hyst_pass_out: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (ctrl_reg[k].hysteresis_select != HYST_RESERVED) |->
      afe_cfg_o[k].hysteresis_select == ctrl_reg[k].hysteresis_select)
      else $error("hysteresis select not passed out");
    a_disabled_no_event: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (!ctrl_reg[k].enable [*2]) |=> (!cmp_event_o[k] && !flag_reg[k]) or $past(flag_reg[k]))
      else $error("disabled comparator made an event");
    a_mux_sel_pass: assert property (@(posedge core_clk_i) disable iff (rst_i)
      afe_cfg_o[k].plus_input_select == mux_reg[k].plus_input_select
      && afe_cfg_o[k].minus_input_select == mux_reg[k].minus_input_select)
      else $error("input select not passed out");
    a_pin_follows_out: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (ctrl_reg[k].enable && inv_route_reg[INV_BIT_BASE + k]) |=>
      cmp_pin_o[k] == !$past(sync2_reg[k]))
      else $error("inverted output not on pin");
    a_event_no_irq: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (cmp_trig[k] && !wr_en && ctrl_reg[k].compare_irq_level == LEVEL_OFF) |=>
      cmp_event_o[k] && !irq_req_o[k])
      else $error("event missing with interrupt off");
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      out_prev_reg <= 2'h0;
      en_d_reg <= 2'h0;
      cmp_pin_reg <= 2'h0;
      cmp_event_reg <= 2'h0;
    end else begin
      out_prev_reg <= cmp_out;
      en_d_reg <= {ctrl_reg[1].enable, ctrl_reg[0].enable};
      cmp_pin_reg <= cmp_out;
      cmp_event_reg <= cmp_trig;
    end
  end

  assign cmp_pin_o = cmp_pin_reg;
  assign cmp_event_o = cmp_event_reg;
  assign supply_scale_num_o = {1'b0, scale_reg} + 7'h01;

  a_scale_num_out: assert property (@(posedge core_clk_i) disable iff (rst_i)
    32'(supply_scale_num_o) == 32'(scale_reg) + 1 && 32'(supply_scale_num_o) <= SCALE_DIVISOR)
    else $error("scaler numerator wrong");

  // ****************************************************************
  // Window mode
  // ****************************************************************
  // Comparator a watches the upper bound, comparator b the lower bound;
  // uses the uninverted synchronised outputs so invert only affects pins, edge events and status output bits
  assign win_on = win_reg.window_enable & ctrl_reg[0].enable & ctrl_reg[1].enable;
  always_comb begin
    win_pos = WIN_OUTSIDE;
    if (!win_on) begin
      win_pos = WIN_ABOVE;
    end else if (sync2_reg[0] && sync2_reg[1]) begin
      win_pos = WIN_ABOVE;
    end else if (!sync2_reg[0] && sync2_reg[1]) begin
      win_pos = WIN_INSIDE;
    end else if (!sync2_reg[0] && !sync2_reg[1]) begin
      win_pos = WIN_BELOW;
    end
  end

  always_comb begin
    case (win_reg.window_trigger_select)
      WIN_ABOVE: win_match = (win_pos == WIN_ABOVE);
      WIN_INSIDE: win_match = (win_pos == WIN_INSIDE);
      WIN_BELOW: win_match = (win_pos == WIN_BELOW);
      default: win_match = (win_pos != WIN_INSIDE);
    endcase
  end
  // Fires on entry into the chosen condition, not on every cycle in it
  assign win_trig = win_on & win_on_d_reg & win_match & ~win_match_prev_reg;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      win_on_d_reg <= 1'b0;
      win_match_prev_reg <= 1'b0;
      window_event_reg <= 1'b0;
    end else begin
      win_on_d_reg <= win_on;
      win_match_prev_reg <= win_match;
      window_event_reg <= win_trig;
    end
  end
  assign window_event_o = window_event_reg;
  assign irq_level_o[FLAG_WINDOW] = win_reg.window_irq_level;

  a_window_off_quiet: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (!win_on) |-> (status_byte[7:6] == WIN_ABOVE) ##1 !window_event_o)
    else $error("window active while disabled");
  a_window_below_code: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (win_on && sync2_reg == 2'b00) |-> status_byte[7:6] == WIN_BELOW)
    else $error("window below code wrong");
  a_window_inside_trig: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (win_on && $past(win_on) && $stable(win_reg) && win_reg.window_trigger_select == WIN_INSIDE
     && win_pos == WIN_INSIDE && $past(win_pos) != WIN_INSIDE) |=> window_event_o && flag_reg[2])
    else $error("entry into window gave no event");

  // ****************************************************************
  // Interrupt flags, sticky status and mask
  // ****************************************************************
  assign trig_all = {win_trig, cmp_trig};
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      flag_reg <= 3'h0;
    end else begin
      // A set arriving with a clear wins
      flag_reg <= (flag_reg & ~(w1c_clear | vec_ack_i)) | trig_all;
    end
  end
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_stat_reg <= 3'h0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~{3{irq_stat_rd_clear}}) | trig_all;
    end
  end
  assign irq_req_o[0] = flag_reg[0] & (ctrl_reg[0].compare_irq_level != LEVEL_OFF);
  assign irq_req_o[1] = flag_reg[1] & (ctrl_reg[1].compare_irq_level != LEVEL_OFF);
  assign irq_req_o[FLAG_WINDOW] = flag_reg[FLAG_WINDOW]
      & (win_reg.window_irq_level != LEVEL_OFF);
  assign irq_o = |(irq_stat_reg & irq_mask_reg);

  a_flag_set_wins: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (trig_all[0] && vec_ack_i[0]) |=> flag_reg[0] && irq_stat_reg[0])
    else $error("flag lost when set and clear met");
  a_flag_ack_clear: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (vec_ack_i[1] && !trig_all[1]) |=> !flag_reg[1])
    else $error("vector ack did not clear flag");
  a_irq_level_gate: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (ctrl_reg[0].compare_irq_level == LEVEL_OFF) |-> !irq_req_o[0])
    else $error("request with level off");
  a_win_irq_gate: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (win_trig && win_reg.window_irq_level != LEVEL_OFF && !vec_ack_i[2]) |=> irq_req_o[2] [*1])
    else $error("window request missing");

  // ****************************************************************
  // AXI4-Lite write channel
  // ****************************************************************
  assign s_axi_awready_o = ~aw_full_reg & ~bvalid_reg;
  assign s_axi_wready_o = ~w_full_reg & ~bvalid_reg;
  assign do_write = aw_full_reg & w_full_reg & ~bvalid_reg;
  assign wr_hit = (aw_idx_reg <= IDX_STATUS) || (aw_idx_reg == IDX_IRQ_STATUS)
      || (aw_idx_reg == IDX_IRQ_MASK);
  assign wr_en = do_write & wr_hit & w_lane0_reg;
  assign w1c_clear = (wr_en && aw_idx_reg == IDX_STATUS) ? (w_byte_reg[2:0] & MASK_FLAGS) : 3'h0;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      aw_idx_reg <= 6'h00;
      w_byte_reg <= RESET_BYTE;
      w_lane0_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= AXI_OKAY;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_full_reg <= 1'b1;
        aw_idx_reg <= s_axi_awaddr_i[7:2];
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_full_reg <= 1'b1;
        w_byte_reg <= s_axi_wdata_i[7:0];
        w_lane0_reg <= s_axi_wstrb_i[0];
      end
      if (do_write) begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_hit ? AXI_OKAY : AXI_SLVERR;
      end else if (bvalid_reg && s_axi_bready_i) begin
        bvalid_reg <= 1'b0;
      end
    end
  end
  assign s_axi_bvalid_o = bvalid_reg;
  assign s_axi_bresp_o = bresp_reg;

  // Reserved positions are masked off, so they always read back as zero
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_reg[0] <= cpc_cmp_ctrl_type'(RESET_BYTE);
      ctrl_reg[1] <= cpc_cmp_ctrl_type'(RESET_BYTE);
      mux_reg[0] <= cpc_mux_type'(RESET_BYTE);
      mux_reg[1] <= cpc_mux_type'(RESET_BYTE);
      inv_route_reg <= RESET_BYTE;
      scale_reg <= RESET_BYTE[5:0];
      win_reg <= cpc_win_type'(RESET_BYTE);
      irq_mask_reg <= RESET_BYTE[2:0];
    end else if (wr_en) begin
      if (aw_idx_reg == IDX_CMP0_CTRL) begin
        ctrl_reg[0] <= cpc_cmp_ctrl_type'(w_byte_reg & MASK_CTRL);
      end else if (aw_idx_reg == IDX_CMP1_CTRL) begin
        ctrl_reg[1] <= cpc_cmp_ctrl_type'(w_byte_reg & MASK_CTRL);
      end else if (aw_idx_reg == IDX_CMP0_MUX) begin
        mux_reg[0] <= cpc_mux_type'(w_byte_reg & MASK_MUX);
      end else if (aw_idx_reg == IDX_CMP1_MUX) begin
        mux_reg[1] <= cpc_mux_type'(w_byte_reg & MASK_MUX);
      end else if (aw_idx_reg == IDX_INV_ROUTE) begin
        inv_route_reg <= w_byte_reg & MASK_INV_ROUTE;
      end else if (aw_idx_reg == IDX_SCALE) begin
        scale_reg <= w_byte_reg[5:0] & MASK_SCALE[5:0];
      end else if (aw_idx_reg == IDX_WINDOW) begin
        win_reg <= cpc_win_type'(w_byte_reg & MASK_WINDOW);
      end else if (aw_idx_reg == IDX_IRQ_MASK) begin
        irq_mask_reg <= w_byte_reg[2:0] & MASK_FLAGS;
      end
    end
  end

  // ****************************************************************
  // AXI4-Lite read channel
  // ****************************************************************
  assign s_axi_arready_o = ~rvalid_reg;
  assign rd_take = s_axi_arvalid_i & ~rvalid_reg;
  assign rd_idx = s_axi_araddr_i[7:2];
  assign status_byte = {win_pos, cmp_out[1], cmp_out[0], 1'b0, flag_reg};
  assign irq_stat_rd_clear = rd_take & (rd_idx == IDX_IRQ_STATUS);

  always_comb begin
    rd_byte = RESET_BYTE;
    rd_hit = 1'b1;
    if (rd_idx == IDX_CMP0_CTRL) begin
      rd_byte = ctrl_reg[0];
    end else if (rd_idx == IDX_CMP1_CTRL) begin
      rd_byte = ctrl_reg[1];
    end else if (rd_idx == IDX_CMP0_MUX) begin
      rd_byte = mux_reg[0];
    end else if (rd_idx == IDX_CMP1_MUX) begin
      rd_byte = mux_reg[1];
    end else if (rd_idx == IDX_INV_ROUTE) begin
      rd_byte = inv_route_reg;
    end else if (rd_idx == IDX_SCALE) begin
      rd_byte = {2'h0, scale_reg};
    end else if (rd_idx == IDX_WINDOW) begin
      rd_byte = win_reg;
    end else if (rd_idx == IDX_STATUS) begin
      rd_byte = status_byte;
    end else if (rd_idx == IDX_IRQ_STATUS) begin
      rd_byte = {5'h00, irq_stat_reg};
    end else if (rd_idx == IDX_IRQ_MASK) begin
      rd_byte = {5'h00, irq_mask_reg};
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= RESET_BYTE;
      rresp_reg <= AXI_OKAY;
    end else if (rd_take) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_byte;
      rresp_reg <= rd_hit ? AXI_OKAY : AXI_SLVERR;
    end else if (rvalid_reg && s_axi_rready_i) begin
      rvalid_reg <= 1'b0;
    end
  end
  assign s_axi_rvalid_o = rvalid_reg;
  assign s_axi_rdata_o = {24'h000000, rdata_reg};
  assign s_axi_rresp_o = rresp_reg;

endmodule : cpc_comparator_pair

// *** testbench/cpc_afe_model.sv ***
// Behavioural model of the analog comparator front end
`timescale 1ns/10ps
module cpc_afe_model (
  // Configuration from the block
  input wire cpc_pkg::cpc_afe_cfg_type [1:0] afe_cfg_i,
  // Which comparators see plus above minus
  input wire logic [1:0] plus_high_i,
  // Raw comparator outputs
  output logic [1:0] comp_raw_o
);
  import cpc_pkg::*;
  // A disabled comparator rests low so it cannot fake an edge
  assign comp_raw_o = plus_high_i & {afe_cfg_i[1].enable, afe_cfg_i[0].enable};
endmodule : cpc_afe_model

// *** testbench/tb_comparator_pair_control.sv ***
// Self-checking bench for the comparator pair control block
`timescale 1ns/10ps
module tb_comparator_pair_control;
  import cpc_pkg::*;
  // ****
  // Signals
  // ****
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] s_axi_awaddr_i = '0, s_axi_araddr_i = '0;
  logic [31:0] s_axi_wdata_i = '0, s_axi_rdata_o, d;
  logic [3:0] s_axi_wstrb_i = 4'hf;
  logic s_axi_awvalid_i = 0, s_axi_wvalid_i = 0, s_axi_bready_i = 0;
  logic s_axi_arvalid_i = 0, s_axi_rready_i = 0, s_axi_awready_o, s_axi_wready_o;
  logic s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o, irq_o, window_event_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, comp_raw_i, cmp_pin_o, cmp_pin_oe_n_o, cmp_event_o, r;
  logic [1:0] plus_high = '0;
  cpc_afe_cfg_type [1:0] afe_cfg_o;
  logic [6:0] supply_scale_num_o;
  logic [2:0] vec_ack_i = '0, irq_req_o;
  logic [2:0][1:0] irq_level_o;
  int failures = 0, comparisons = 0, cycles = 0, ev_a = 0, ev_b = 0, ev_w = 0, n0, n1, i;
  logic [7:0] masks [7] = '{MASK_CTRL, MASK_CTRL, MASK_MUX, MASK_MUX, MASK_INV_ROUTE,
    MASK_SCALE, MASK_WINDOW};
  logic [7:0] ctrls [4] = '{8'h10, 8'h11, 8'h81, 8'hd1};
  int counts [4] = '{0, 2, 1, 1};
  logic [1:0] spots [4] = '{2'b11, 2'b10, 2'b00, 2'b01};

  always #4 core_clk_i = ~core_clk_i;

  cpc_comparator_pair cpc_comparator_pair_i (.core_clk_i, .rst_i, .s_axi_awaddr_i,
    .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i,
    .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i,
    .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o,
    .s_axi_rready_i, .comp_raw_i, .afe_cfg_o, .supply_scale_num_o, .cmp_pin_o,
    .cmp_pin_oe_n_o, .cmp_event_o, .window_event_o, .vec_ack_i, .irq_req_o, .irq_level_o,
    .irq_o);

  cpc_afe_model cpc_afe_model_i (.afe_cfg_i(afe_cfg_o), .plus_high_i(plus_high),
    .comp_raw_o(comp_raw_i));

  // Event pulses last one cycle, so they are counted rather than sampled once
  always @(posedge core_clk_i) begin
    cycles <= cycles + 1;
    ev_a <= ev_a + int'(cmp_event_o[0] === 1'b1);
    ev_b <= ev_b + int'(cmp_event_o[1] === 1'b1);
    ev_w <= ev_w + int'(window_event_o === 1'b1);
    if (cycles == 20000) begin
      failures++;
      give_verdict();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic give_verdict();
    if (failures == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict

  task automatic settle();
    repeat (8) @(posedge core_clk_i);
  endtask : settle

  task automatic wr(input logic [5:0] idx, input logic [7:0] v);
    logic a;
    logic w;
    a = 1'b0;
    w = 1'b0;
    @(posedge core_clk_i);
    s_axi_awaddr_i <= {idx, 2'b00};
    s_axi_wdata_i <= {24'h0, v};
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    while (!(a && w)) begin
      @(posedge core_clk_i);
      if (!a && s_axi_awready_o === 1'b1) begin
        a = 1'b1;
        s_axi_awvalid_i <= 1'b0;
      end
      if (!w && s_axi_wready_o === 1'b1) begin
        w = 1'b1;
        s_axi_wvalid_i <= 1'b0;
      end
    end
    do @(posedge core_clk_i); while (s_axi_bvalid_o !== 1'b1);
    r = s_axi_bresp_o;
    s_axi_bready_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [5:0] idx);
    @(posedge core_clk_i);
    s_axi_araddr_i <= {idx, 2'b00};
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    do @(posedge core_clk_i); while (s_axi_arready_o !== 1'b1);
    s_axi_arvalid_i <= 1'b0;
    while (s_axi_rvalid_o !== 1'b1) @(posedge core_clk_i);
    d = s_axi_rdata_o;
    r = s_axi_rresp_o;
    s_axi_rready_i <= 1'b0;
  endtask : rd

  initial begin
    repeat (20) @(posedge core_clk_i);
    rst_i <= 1'b0;
    for (i = 0; i < 7; i++) begin
      rd(i[5:0]);
      chk(d, 32'h0);
      wr(i[5:0], 8'hff);
      rd(i[5:0]);
      chk(d, {24'h0, masks[i]});
      wr(i[5:0], 8'h00);
    end
    rd(6'h08);
    chk(d, 32'h0);
    chk(32'(r), 32'(AXI_SLVERR));
    wr(6'h08, 8'h5a);
    chk(32'(r), 32'(AXI_SLVERR));
    wr(IDX_SCALE, 8'h3f);
    chk(32'({r, supply_scale_num_o}), 32'({AXI_OKAY, 7'h40}));
    wr(IDX_CMP0_MUX, 8'h3e);
    wr(IDX_CMP0_CTRL, 8'h07);
    chk(32'(afe_cfg_o[0].hysteresis_select), 32'(HYST_NONE));
    wr(IDX_CMP0_CTRL, 8'h05);
    chk(32'(afe_cfg_o[0]), 32'({1'b1, 2'h2, 3'h7, 3'h6}));
    // Disabled, any edge, falling without interrupt, rising with interrupt
    for (i = 0; i < 4; i++) begin
      wr(IDX_CMP0_CTRL, ctrls[i]);
      settle();
      n0 = ev_a;
      plus_high <= 2'b01;
      settle();
      plus_high <= 2'b00;
      settle();
      chk(ev_a - n0, counts[i]);
    end
    chk(32'({irq_req_o[0], irq_level_o[0]}), 32'h5);
    vec_ack_i <= 3'h7;
    @(posedge core_clk_i);
    vec_ack_i <= 3'h0;
    @(posedge core_clk_i);
    chk(32'(irq_req_o[0]), 32'h0);
    // Acknowledge lands on the same edge that a rising output sets the flag
    plus_high <= 2'b01;
    repeat (2) @(posedge core_clk_i);
    vec_ack_i <= 3'h1;
    @(posedge core_clk_i);
    vec_ack_i <= 3'h0;
    @(posedge core_clk_i);
    chk(32'(irq_req_o[0]), 32'h1);
    plus_high <= 2'b00;
    wr(IDX_INV_ROUTE, 8'h05);
    settle();
    chk(32'({cmp_pin_oe_n_o, cmp_pin_o[0]}), 32'h5);
    wr(IDX_INV_ROUTE, 8'h00);
    wr(IDX_CMP1_CTRL, 8'h01);
    plus_high <= 2'b11;
    wr(IDX_WINDOW, 8'h15);
    settle();
    wr(IDX_STATUS, 8'h07);
    rd(IDX_IRQ_STATUS);
    wr(IDX_IRQ_MASK, 8'h04);
    n0 = ev_w;
    n1 = ev_b;
    for (i = 0; i < 4; i++) begin
      plus_high <= spots[i];
      settle();
      rd(IDX_STATUS);
      chk(32'(d[7:6]), 32'(i[1:0]));
      if (i == 0) chk(32'(d[2:0]), 32'h0);
      if (i == 1) begin
        chk(32'({irq_o, d[2], irq_req_o[2], irq_level_o[2]}), 32'h1d);
      end
    end
    rd(IDX_IRQ_STATUS);
    chk(32'({irq_o, d[2], irq_req_o[1]}), 32'h2);
    chk(ev_w - n0, 1);
    chk(ev_b - n1, 1);
    wr(IDX_WINDOW, 8'h00);
    rd(IDX_STATUS);
    chk(32'(d[7:6]), 32'(WIN_ABOVE));
    give_verdict();
  end
endmodule : tb_comparator_pair_control
